// file: rtl/cmd_pkg.sv
// Package for the clock monitor and DCO divider block.
// Assumes a single 250 MHz clock; all other clocks arrive as sampled pins.
package cmd_pkg;
  // Clock period, ns
  localparam int unsigned CLK_PERIOD_NS = 4;
  // Flag bit position in the control word read by software
  localparam int unsigned FLAG_BIT      = 6;
  // Divider control saturation code and widths
  localparam logic [3:0]  DIV_MAX       = 4'h9;
  localparam int unsigned DIV_W         = 4;
  localparam int unsigned STG_W         = 8;
  localparam int unsigned CNT_W         = 10;
  // Missed-edge count that declares the external clock inactive
  localparam logic [1:0]  MISS_LIMIT    = 2'h2;
  // Reset values
  localparam logic [3:0]  DIV_RST       = 4'h0;
  localparam logic [7:0]  STG_RST       = 8'h80;

  // Loop filter step request
  typedef struct packed {
    logic       add;   // Add step to stage word
    logic       sub;   // Subtract step from stage word
    logic [7:0] step;  // Step size
  } cmd_step_t;

  // Software write to the control word
  typedef struct packed {
    logic wr;              // Write strobe
    logic rd;              // Read strobe
    logic monitor_enable;
    logic monitor_irq_enable;
    logic monitor_flag;
    logic clk_sel;         // 1 selects external clock
  } cmd_ctl_wr_t;

  // Selection states of the clock switch
  typedef enum logic [1:0] {SW_INT, SW_EXT, SW_HOLD} cmd_sw_t;
endpackage

// file: rtl/cmd_clock_monitor.sv
// Clock monitor control, fallback switch select and DCO binary divider.
// Assumes external clock, internal reference and stable indications are
// asynchronous pins sampled on ref_clk_i; the ring oscillator is a pin too.
//
// Notes on behaviour
// - Monitor enable needs both generators on
// - Monitor enable needs both clocks stable
// - Interrupt enable only after monitor enable
// - Flag readable at control bit six
// - Flag clears by read then zero write
// - Clearing enable reconfigures reference dividers
// - Enable stays set despite lost stability
// - Inactive source deselected, active one chosen
// - Select bit shows the chosen source
// - Period set by stage and divider words
// - Divide ring by two to divider value
// - Divider code saturates at nine
// - Increment doubles, decrement halves period
// - Divider moves only on stage carry/borrow
// - External inactive after two missed edges
// - Active side selected one to two later
// - Reset selects the internal clock
`timescale 1ns/1ps
`default_nettype none
module cmd_clock_monitor
  import cmd_pkg::*;
#(
  parameter int unsigned MAX_DIV_CODE = 9   // Highest divider code served
) (
  input  wire logic        ref_clk_i,            // Block clock, 250 MHz
  input  wire logic        sys_rst_i,            // Async reset, active high
  input  wire logic        ext_gen_on_i,         // External generator on
  input  wire logic        int_gen_on_i,         // Internal generator on
  input  wire logic        ext_gen_stable_i,     // External clock stable (pin)
  input  wire logic        int_gen_stable_i,     // Internal clock stable (pin)
  input  wire logic        external_clock_i,     // External clock (pin)
  input  wire logic        internal_reference_i, // Internal reference (pin)
  input  wire logic        int_inactive_i,       // Internal inactive (pin)
  input  wire logic        ring_clock_i,         // Ring oscillator output (pin)
  input  wire cmd_ctl_wr_t ctl_i,                // Software access
  input  wire cmd_step_t   step_i,               // Loop filter step request
  output logic [7:0]       ctl_rdata_o,          // Control word readback
  output logic             monitor_irq_o,        // Monitor interrupt request
  output logic             osc_sel_ext_o,        // Oscillator output uses external
  output logic             tb_sel_ext_o,         // Timebase clock uses external
  output logic             ref_div_reload_o,     // Reference divider reconfigure pulse
  output logic             ext_inactive_o,       // External clock inactive
  output logic [7:0]       stage_control_o,      // Stage control word
  output logic [3:0]       divider_control_o,    // Divider control word
  output logic             internal_clock_o      // Divided ring clock
);

  initial begin
    if (MAX_DIV_CODE != 9) begin
      $error("MAX_DIV_CODE must be 9");
    end
  end

  // Two-flop synchronisers for all asynchronous pins
  logic [5:0] sync_a;   // First stage, read only by second stage
  logic [5:0] sync_b;   // Usable synchronised values
  logic       ext_stb, int_stb, external_clock_s, internal_reference_s, int_inactive_s, ring_s;

  // Pin synchronisers
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync_a <= 6'h00;
      sync_b <= 6'h00;
    end else begin
      sync_a <= {ring_clock_i, int_inactive_i, internal_reference_i,
                 external_clock_i, int_gen_stable_i, ext_gen_stable_i};
      sync_b <= sync_a;
    end
  end
  assign {ring_s, int_inactive_s, internal_reference_s, external_clock_s, int_stb, ext_stb} = sync_b;

  // Control state
  logic monitor_enable;     // Monitor running
  logic monitor_irq_enable; // Interrupt gate
  logic monitor_flag;       // Sticky loss flag
  logic flag_read_armed;    // Flag was read while set
  logic clk_sel;            // Oscillator output source, 1 = external
  logic loss;               // Loss event this cycle

  // Monitor enable register
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      monitor_enable <= 1'b0;
    end else if (ctl_i.wr) begin
      if (!ctl_i.monitor_enable) begin
        monitor_enable <= 1'b0;
      end else if (ext_gen_on_i && int_gen_on_i && ext_stb && int_stb) begin
        monitor_enable <= 1'b1;
      end
    end
  end

  // Interrupt enable: only when monitor enable is already set
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      monitor_irq_enable <= 1'b0;
    end else if (ctl_i.wr) begin
      if (!ctl_i.monitor_irq_enable || !ctl_i.monitor_enable) begin
        monitor_irq_enable <= 1'b0;
      end else if (monitor_enable) begin
        monitor_irq_enable <= 1'b1;
      end
      // A combined write sets enable first; a repeat write then sets this
    end
  end

  logic [1:0] miss_cnt;   // Low phases without a falling edge
  logic       external_clock_d;     // Last external sample
  logic       internal_reference_d;     // Last reference sample
  logic       seen_edge;  // Falling edge seen this low phase
  logic       external_clock_fall;
  logic       internal_reference_rise;
  logic       low_open;   // Reference has gone low since reset
  assign external_clock_fall = external_clock_d && !external_clock_s;
  assign internal_reference_rise = !internal_reference_d && internal_reference_s;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      external_clock_d         <= 1'b0;
      internal_reference_d         <= 1'b0;
      low_open       <= 1'b0;
      seen_edge      <= 1'b0;
      miss_cnt       <= 2'h0;
      ext_inactive_o <= 1'b0;
    end else begin
      external_clock_d <= external_clock_s;
      internal_reference_d <= internal_reference_s;
      // A rise straight out of reset closes no real low phase, so wait for a fall
      if (internal_reference_d && !internal_reference_s) begin
        low_open <= 1'b1;
      end
      if (!internal_reference_s && external_clock_fall) begin
        // Edge during low phase clears at once
        seen_edge      <= 1'b1;
        miss_cnt       <= 2'h0;
        ext_inactive_o <= 1'b0;
      end else if (internal_reference_rise) begin
        // End of a low phase: score it
        seen_edge <= 1'b0;
        if (!seen_edge && low_open) begin
          if (miss_cnt + 2'h1 >= MISS_LIMIT) begin
            ext_inactive_o <= 1'b1;
            miss_cnt       <= MISS_LIMIT;
          end else begin
            miss_cnt <= miss_cnt + 2'h1;
          end
        end
      end
    end
  end

  // Loss only counts while monitor runs; new loss is edge of inactive
  logic loss_d;
  logic loss_lvl;
  assign loss_lvl = monitor_enable && (ext_inactive_o || int_inactive_s);
  assign loss     = loss_lvl && !loss_d;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      loss_d <= 1'b0;
    end else begin
      loss_d <= loss_lvl;
    end
  end

  // Flag: set wins over the clear
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      monitor_flag    <= 1'b0;
      flag_read_armed <= 1'b0;
    end else begin
      if (ctl_i.rd && monitor_flag) begin
        flag_read_armed <= 1'b1;
      end
      if (loss) begin
        monitor_flag <= 1'b1;
      end else if (ctl_i.wr && !ctl_i.monitor_flag && flag_read_armed) begin
        monitor_flag    <= 1'b0;
        flag_read_armed <= 1'b0;
      end
    end
  end

  // Source select with forced fallback
  cmd_sw_t sw_state;   // Switch synchroniser state
  logic    sw_target;  // Side to select after hold

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      clk_sel       <= 1'b0;
      sw_state      <= SW_INT;
      sw_target     <= 1'b0;
      osc_sel_ext_o <= 1'b0;
    end else begin
      if (loss && ext_inactive_o) begin
        clk_sel <= 1'b0;
      end else if (loss) begin
        clk_sel <= 1'b1;
      end else if (ctl_i.wr && ctl_i.clk_sel != clk_sel && ext_gen_on_i && int_gen_on_i &&
                   (ctl_i.clk_sel ? ext_stb : int_stb)) begin
        clk_sel <= ctl_i.clk_sel;
      end
      case (sw_state)
        SW_INT, SW_EXT: begin
          if (clk_sel != osc_sel_ext_o) begin
            // deselect now, select one cycle later
            sw_target <= clk_sel;
            sw_state  <= SW_HOLD;
          end
        end
        SW_HOLD: begin
          osc_sel_ext_o <= sw_target;
          sw_state      <= sw_target ? SW_EXT : SW_INT;
        end
        default: sw_state <= SW_INT;
      endcase
    end
  end

  // Timebase follows generator-on, overridden by fallback
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tb_sel_ext_o <= 1'b0;
    end else begin
      if (monitor_enable && ext_inactive_o) begin
        tb_sel_ext_o <= 1'b0;
      end else if (monitor_enable && int_inactive_s) begin
        tb_sel_ext_o <= 1'b1;
      end else begin
        tb_sel_ext_o <= ext_gen_on_i;
      end
    end
  end

  // Readback, interrupt and divider reload pulse
  logic mon_en_d;
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctl_rdata_o      <= 8'h00;
      monitor_irq_o    <= 1'b0;
      mon_en_d         <= 1'b0;
      ref_div_reload_o <= 1'b0;
    end else begin
      ctl_rdata_o <= {monitor_irq_enable, monitor_flag, monitor_enable, clk_sel,
                      int_gen_on_i, int_stb, ext_gen_on_i, ext_stb};
      monitor_irq_o <= monitor_flag && monitor_irq_enable;
      mon_en_d      <= monitor_enable;
      ref_div_reload_o <= mon_en_d && !monitor_enable;
    end
  end

  // Stage and divider words
  logic [8:0] stg_sum;
  always_comb begin
    stg_sum = 9'h000;
    if (step_i.add) begin
      stg_sum = {1'b0, stage_control_o} + {1'b0, step_i.step};
    end else if (step_i.sub) begin
      stg_sum = {1'b0, stage_control_o} - {1'b0, step_i.step};
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stage_control_o   <= STG_RST;
      divider_control_o <= DIV_RST;
    end else if (step_i.add != step_i.sub) begin
      stage_control_o <= stg_sum[7:0];
      if (stg_sum[8] && step_i.add && divider_control_o < DIV_MAX) begin
        divider_control_o <= divider_control_o + 4'h1;
      end else if (stg_sum[8] && step_i.sub && divider_control_o != 4'h0) begin
        divider_control_o <= divider_control_o - 4'h1;
      end
    end
  end

  function automatic logic [3:0] eff_div(input logic [3:0] code);
    eff_div = (code > DIV_MAX) ? DIV_MAX : code;
  endfunction

  // Binary divider on both rising and falling ring edges
  logic [CNT_W-1:0] ring_cnt;  // Ripple count of ring edges
  logic             ring_d;
  logic [CNT_W-1:0] next_ring_cnt;
  assign next_ring_cnt = ring_cnt + {{(CNT_W-1){1'b0}}, 1'b1};

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ring_d           <= 1'b0;
      ring_cnt         <= '0;
      internal_clock_o <= 1'b0;
    end else begin
      ring_d <= ring_s;
      if (ring_s != ring_d) begin
        ring_cnt <= next_ring_cnt;
        if (eff_div(divider_control_o) == 4'h0) begin
          internal_clock_o <= ring_s;
        end else begin
          internal_clock_o <= next_ring_cnt[eff_div(divider_control_o)];
        end
      end
    end
  end

endmodule
`default_nettype wire

// file: test/cmd_clock_monitor_sva.sv
// Checker for the clock monitor and DCO divider block.
// Assumes it is bound to cmd_clock_monitor and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module cmd_clock_monitor_sva
  import cmd_pkg::*;
#(
  parameter int unsigned MAX_DIV_CODE = 9   // Highest divider code served
) (
  input wire logic       ref_clk_i,
  input wire logic       sys_rst_i,
  input wire logic       ext_gen_on_i,
  input wire logic       int_gen_on_i,
  input wire cmd_step_t  step_i,
  input wire logic [7:0] ctl_rdata_o,
  input wire logic       monitor_irq_o,
  input wire logic       osc_sel_ext_o,
  input wire logic       tb_sel_ext_o,
  input wire logic       ref_div_reload_o,
  input wire logic       ext_inactive_o,
  input wire logic [7:0] stage_control_o,
  input wire logic [3:0] divider_control_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // External loss seen while the monitor runs
  sequence ext_loss_s;
    $rose(ext_inactive_o) && ctl_rdata_o[5];
  endsequence
  // Both switches back on the internal side, allowing synchronizer delay
  sequence int_side_s;
    ##[0:3] (!osc_sel_ext_o && !tb_sel_ext_o);
  endsequence
  gen_on_gate_a: assert property (
    $rose(ctl_rdata_o[5]) |-> $past(ext_gen_on_i && int_gen_on_i, 2))
    else $error("monitor enabled with a generator off");
  irq_order_a: assert property (
    $rose(ctl_rdata_o[7]) |-> $past(ctl_rdata_o[5]))
    else $error("interrupt enable set before monitor enable");
  irq_level_a: assert property (
    monitor_irq_o == (ctl_rdata_o[6] && ctl_rdata_o[7]))
    else $error("interrupt request not flag and enable");
  flag_cause_a: assert property (
    $rose(ctl_rdata_o[6]) |-> $past(ctl_rdata_o[5]))
    else $error("flag set with monitor off");
  reload_pulse_a: assert property (
    $fell(ctl_rdata_o[5]) |-> ref_div_reload_o || $past(ref_div_reload_o))
    else $error("no divider reload on monitor disable");
  div_sat_a: assert property (
    divider_control_o <= 4'(MAX_DIV_CODE))
    else $error("divider code above saturation");
  div_cause_a: assert property (
    $changed(divider_control_o) |-> $past(step_i.add || step_i.sub))
    else $error("divider moved without a stage step");
  stage_add_a: assert property (
    $past(step_i.add && !step_i.sub) |->
      stage_control_o == $past(stage_control_o) + $past(step_i.step))
    else $error("stage word add wrong");
  fallback_a: assert property (
    ext_loss_s |-> int_side_s)
    else $error("no fallback to internal clock");
endmodule
bind cmd_clock_monitor cmd_clock_monitor_sva #(.MAX_DIV_CODE(MAX_DIV_CODE)) u_cmd_clock_monitor_sva (
  .ref_clk_i, .sys_rst_i, .ext_gen_on_i, .int_gen_on_i, .step_i, .ctl_rdata_o, .monitor_irq_o,
  .osc_sel_ext_o, .tb_sel_ext_o, .ref_div_reload_o, .ext_inactive_o, .stage_control_o, .divider_control_o);
`default_nettype wire

// file: test/cmd_clock_monitor_test.sv
// Self-checking bench for the clock monitor and DCO divider block.
// Assumes the checker file is compiled alongside; the bench drives all pins.
`timescale 1ns/1ps
`default_nettype none
module cmd_clock_monitor_test
  import cmd_pkg::*;
;
  logic        ref_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        ext_on = 1'b0, int_on = 1'b0, ext_st = 1'b0, int_st = 1'b0;
  logic        ext_clk = 1'b0, int_ref = 1'b1, ring_clk = 1'b0;
  cmd_ctl_wr_t ctl = '0;
  cmd_step_t   stp = '0;
  logic [7:0]  rdata, stage;
  logic [3:0]  div;
  logic        irq, osc_ext, tb_ext, reload, ext_off, internal_clock;
  logic        int_off = 1'b0;     // Internal inactive pin
  int          reload_cnt = 0;     // Reload pulses seen so far
  logic [7:0]  s = STG_RST;        // Expected stage word
  logic [3:0]  d = DIV_RST;        // Expected divider code
  int          error_cnt = 0;
  int          checked = 0;
  int          n;

  // Free-running block clock
  initial forever #2 ref_clk_i = ~ref_clk_i;
  // Count reload pulses; one disable must give exactly one
  always @(posedge ref_clk_i) if (reload === 1'b1) reload_cnt <= reload_cnt + 1;

  cmd_clock_monitor u_cmd_clock_monitor (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .ext_gen_on_i(ext_on), .int_gen_on_i(int_on),
    .ext_gen_stable_i(ext_st), .int_gen_stable_i(int_st), .external_clock_i(ext_clk),
    .internal_reference_i(int_ref), .int_inactive_i(int_off), .ring_clock_i(ring_clk), .ctl_i(ctl),
    .step_i(stp), .ctl_rdata_o(rdata), .monitor_irq_o(irq), .osc_sel_ext_o(osc_ext),
    .tb_sel_ext_o(tb_ext), .ref_div_reload_o(reload), .ext_inactive_o(ext_off),
    .stage_control_o(stage), .divider_control_o(div), .internal_clock_o(internal_clock));

  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({7'h0, got}, {7'h0, exp});
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk_i);
  endtask
  // Generator on and stable pins, then time for the synchronizers
  task automatic pins(input logic [3:0] v);
    @(posedge ref_clk_i);
    {ext_on, int_on, ext_st, int_st} <= v;
    cyc(4);
    #1;
  endtask
  // One access: r high reads, else writes fields {mon, irq, flag, sel}
  task automatic wr(input logic r, input logic [3:0] f);
    @(posedge ref_clk_i);
    ctl <= {~r, r, f};
    @(posedge ref_clk_i);
    ctl <= '0;
    cyc(3);
    #1;
  endtask
  // Toggle the reference (and optionally the external clock) until ext_off reads want
  task automatic run_ref(input logic want, input logic tog);
    n = 0;
    while (ext_off !== want && n < 96) begin
      @(posedge ref_clk_i);
      int_ref <= n[3];
      ext_clk <= tog & n[1];
      n++;
    end
    if (n >= 96) begin
      error_cnt++;
      final_report;
    end
    #1;
  endtask

  task automatic t_enable;
    pins(4'h3);
    wr(0, 4'h8);
    chkb(rdata[5], 1'b0);
    pins(4'hc);
    wr(0, 4'h8);
    chkb(rdata[5], 1'b0);
    pins(4'hf);
    wr(0, 4'hd);
    chkb(rdata[5], 1'b1);
    chkb(rdata[7], 1'b0);
    chkb(osc_ext, 1'b1);
    wr(0, 4'hd);
    chkb(rdata[7], 1'b1);
    pins(4'he);
    chkb(rdata[5], 1'b1);
    pins(4'hf);
    $display("enable test done");
  endtask
  task automatic t_loss;
    run_ref(1'b1, 1'b0);
    cyc(4);
    #1;
    chkb(rdata[6], 1'b1);
    chkb(irq, 1'b1);
    chk({6'h0, osc_ext, tb_ext}, 8'h00);
    chkb(rdata[4], 1'b0);
    wr(0, 4'hc);
    chkb(rdata[6], 1'b1);
    wr(1, 4'h0);
    wr(0, 4'he);
    chkb(rdata[6], 1'b1);
    wr(1, 4'h0);
    wr(0, 4'hc);
    chkb(rdata[6], 1'b0);
    chkb(irq, 1'b0);
    run_ref(1'b0, 1'b1);
    n = reload_cnt;
    wr(0, 4'h0);
    chk(8'(reload_cnt - n), 8'h01);
    wr(0, 4'h8);
    @(posedge ref_clk_i);
    int_off <= 1'b1;
    cyc(6);
    #1;
    chkb(rdata[6], 1'b1);
    chkb(irq, 1'b0);
    chk({6'h0, osc_ext, tb_ext}, 8'h03);
    chkb(rdata[4], 1'b1);
    @(posedge ref_clk_i);
    int_off <= 1'b0;
    wr(1, 4'h0);
    wr(0, 4'h0);
    chkb(rdata[6], 1'b0);
    chkb(osc_ext, 1'b0);
    $display("loss test done");
  endtask
  // Count divided clock rises over k ring rises; sync slip allows one off
  task automatic ring(input int k, input int e);
    int c;
    logic p;
    c = 0;
    p = internal_clock;
    for (int i = 0; i < 4 * k; i++) begin
      @(posedge ref_clk_i);
      ring_clk <= i[1];
      if (internal_clock === 1'b1 && p === 1'b0) c++;
      p = internal_clock;
    end
    chkb(c >= e - 1 && c <= e + 1, 1'b1);
    $display("ring test done");
  endtask
  task automatic stepd(input logic a, input logic [7:0] v);
    logic [8:0] r;
    r = a ? {1'b0, s} + v : {1'b0, s} - v;
    s = r[7:0];
    if (r[8] && a && d < DIV_MAX) d = d + 4'h1;
    if (r[8] && !a && d > 4'h0) d = d - 4'h1;
    @(posedge ref_clk_i);
    stp <= '{add: a, sub: ~a, step: v};
    @(posedge ref_clk_i);
    stp <= '0;
    cyc(2);
    #1;
    chk(stage, s);
    chk({4'h0, div}, {4'h0, d});
  endtask
  task automatic t_div;
    repeat (11) stepd(1'b1, 8'hff);
    stepd(1'b0, 8'h01);
    stepd(1'b0, 8'hff);
    $display("divider test done");
  endtask
  task automatic t_rst2;
    wr(0, 4'h1);
    chkb(osc_ext, 1'b1);
    @(posedge ref_clk_i);
    sys_rst_i <= 1'b1;
    cyc(2);
    #1;
    chkb(osc_ext, 1'b0);
    chk(stage, STG_RST);
    @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    cyc(2);
    #1;
    chkb(osc_ext, 1'b0);
    $display("second reset test done");
  endtask

  initial begin
    cyc(4);
    sys_rst_i <= 1'b0;
    cyc(2);
    #1;
    chkb(osc_ext, 1'b0);
    chk(stage, STG_RST);
    t_enable;
    t_loss;
    ring(16, 16);
    t_div;
    ring(1024, 4);
    t_rst2;
    final_report;
  end
endmodule
`default_nettype wire
